// ---- logic/aso_formatter.sv ----
`timescale 1ns/100ps
`include "aso_map.svh"

module aso_formatter #(
  parameter int NUM_CH = 8
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_b,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic      [7:0]            o_reg_rdata,
  input  wire logic                  i_sample_valid,
  input  wire logic [NUM_CH*14-1:0]  i_sample_data,
  output logic                       o_sample_ready,
  output logic      [NUM_CH-1:0]     o_bank1_serial_lanes,
  output logic      [NUM_CH-1:0]     o_bank2_serial_lanes,
  output logic                       o_bank1_bit_clock,
  output logic                       o_bank2_bit_clock,
  output logic                       o_bank1_word_marker,
  output logic                       o_bank2_word_marker
);

  localparam int BUF_W = NUM_CH * 14;

  typedef struct packed {
    logic [7:0]                   test;
    logic [7:0]                   fmt;
    logic [7:0]                   lfmt;
    logic [7:0]                   drive;
    logic [7:0]                   phase;
    logic [7:0]                   u1_low;
    logic [7:0]                   u1_high;
    logic [7:0]                   u2_low;
    logic [7:0]                   u2_high;
    logic [7:0]                   pll;
    logic [7:0]                   rdata;
    logic [1:0][BUF_W-1:0]        mem;
    logic                         wp;
    logic                         rp;
    logic [1:0]                   cnt;
    logic [BUF_W-1:0]             held;
    logic [NUM_CH-1:0][15:0]      words;
    logic [2:0]                   step;
    logic [3:0]                   idx;
    logic                         alt;
    logic [8:0]                   pn9;
    logic [22:0]                  pn23;
    logic [2*NUM_CH-1:0]          lanes;
    logic                         bclk;
    logic                         frame;
  } aso_state_t;

  aso_state_t q;
  aso_state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // pseudorandom helpers: step the register fourteen times per word

  function automatic logic [8:0] pn9_adv(input logic [8:0] s);
    logic [8:0] r;
    r = s;
    for (int i = 0; i < 14; i++)
    begin
      r = {r[7:0], r[8] ^ r[4]};
    end
    return r;
  endfunction : pn9_adv

  function automatic logic [22:0] pn23_adv(input logic [22:0] s);
    logic [22:0] r;
    r = s;
    for (int i = 0; i < 14; i++)
    begin
      r = {r[21:0], r[22] ^ r[17]};
    end
    return r;
  endfunction : pn23_adv

  // first fourteen stream bits of a short-generator state, oldest bit first
  function automatic logic [13:0] pn9_bits(input logic [8:0] s);
    logic [8:0]  r;
    logic [13:0] o;
    r = s;
    o = 14'h0000;
    for (int i = 0; i < 14; i++)
    begin
      o = {o[12:0], r[8]};
      r = {r[7:0], r[8] ^ r[4]};
    end
    return o;
  endfunction : pn9_bits

  ////////////////////////////////////////////////////////////////////////////
  // word timing shared by every channel

  logic       offbin;
  logic       one_lane;
  logic       lsb_first;
  logic       res12;
  logic       res12_load;
  logic [3:0] half_word;
  logic [3:0] mode;
  logic       test_on;
  logic [3:0] bits_per_lane;
  logic [4:0] word_len;
  logic       word_end;
  logic [4:0] t_in_bck;
  logic [4:0] ph;
  logic [4:0] rel;

  assign offbin    = q.fmt[`ASO_FMT_OFFBIN];
  // lane layout follows the format latched at the last word boundary, so a write never cuts a bit
  assign one_lane   = q.lfmt[`ASO_FMT_ONE_LANE];
  assign lsb_first  = q.lfmt[`ASO_FMT_LSB_FIRST];
  assign res12      = q.lfmt[`ASO_FMT_RES12];
  assign res12_load = q.fmt[`ASO_FMT_RES12];
  assign mode      = q.test[3:0];
  assign test_on   = (mode != `ASO_TM_OFF);

  // lane word length: 8 or 6 bits on two lanes, 16 or 12 on one
  always_comb
  begin
    if (one_lane)
      bits_per_lane = res12 ? `ASO_BITS_ONE12 + 4'd1 : `ASO_BITS_ONE16 + 4'd1;
    else
      bits_per_lane = res12 ? `ASO_BITS_TWO12 : `ASO_BITS_TWO16;
  end
  // a 16-lane-bit count of 16 wraps to 0 in 4 bits, so compare against len-1
  assign word_len = res12 ? 5'd12 : 5'd16;
  assign word_end = (q.step == `ASO_STEPS_PER_BIT - 3'd1) && (q.idx == bits_per_lane - 4'd1);
  // marker high for the first half of the lane bits; one-lane 16 needs the 5-bit length
  assign half_word = one_lane ? word_len[4:1] : {1'b0, bits_per_lane[3:1]};

  // bit clock: one period spans two data bits, shifted by the phase setting
  assign t_in_bck = q.idx[0] ? {2'b00, q.step} + 5'd6 : {2'b00, q.step};
  assign ph       = (q.phase[4:0] > `ASO_PHASE_MAX) ? `ASO_PHASE_MAX : q.phase[4:0];
  always_comb
  begin
    rel = t_in_bck + `ASO_STEPS_PER_BCK - ph;
    if (rel >= `ASO_STEPS_PER_BCK)
      rel = rel - `ASO_STEPS_PER_BCK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // test pattern choice, common to all channels

  logic [15:0] pat;
  logic        pat_fmt;
  logic [15:0] user1;
  logic [15:0] user2;
  logic [15:0] pn9_word;
  logic [15:0] pn23_word;

  assign user1     = {q.u1_high, q.u1_low};
  assign user2     = {q.u2_high, q.u2_low};
  assign pn9_word  = {pn9_bits(q.pn9), 2'b00};
  assign pn23_word = {q.pn23[22:9], 2'b00};

  always_comb
  begin
    pat     = `ASO_PAT_ZERO;
    pat_fmt = 1'b0;
    case (mode)
      `ASO_TM_MID:
      begin
        pat     = `ASO_PAT_MID;
        pat_fmt = 1'b1;
      end
      `ASO_TM_POS_FS:
      begin
        pat     = `ASO_PAT_POS_FS;
        pat_fmt = 1'b1;
      end
      `ASO_TM_NEG_FS:
      begin
        pat     = `ASO_PAT_ZERO;
        pat_fmt = 1'b1;
      end
      `ASO_TM_CHECKER: pat = q.alt ? `ASO_PAT_CHK_B : `ASO_PAT_CHK_A;
      `ASO_TM_PN23:
      begin
        pat     = pn23_word;
        pat_fmt = 1'b1;
      end
      `ASO_TM_PN9:
      begin
        pat     = pn9_word;
        pat_fmt = 1'b1;
      end
      `ASO_TM_WORD_TOG: pat = q.alt ? `ASO_PAT_ZERO : `ASO_PAT_POS_FS;
      `ASO_TM_USER:     pat = q.alt ? user2 : user1;
      `ASO_TM_BIT_TOG:  pat = `ASO_PAT_CHK_A;
      `ASO_TM_SYNC:     pat = res12_load ? `ASO_PAT_SYNC12 : `ASO_PAT_SYNC16;
      `ASO_TM_ONE_BIT:  pat = `ASO_PAT_MID;
      `ASO_TM_MIXED:    pat = res12_load ? `ASO_PAT_MIXED12 : `ASO_PAT_MIXED16;
      default:          pat = `ASO_PAT_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel: format the next word and pick this step's lane bits

  logic [BUF_W-1:0]          src;
  logic [NUM_CH-1:0][15:0]   fmt_word;
  logic [2*NUM_CH-1:0]       lane_bits;
  logic [4:0]                pos1;
  logic [4:0]                pos0;

  // an empty buffer repeats the last sample rather than sending stale zeros
  assign src  = (q.cnt != 2'd0) ? q.mem[q.rp] : q.held;
  assign pos1 = one_lane ? {1'b0, q.idx} : {q.idx, 1'b0};
  assign pos0 = one_lane ? {1'b0, q.idx} : {q.idx, 1'b1};

  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_lane
      aso_pkg::aso_word_t samp;
      aso_pkg::aso_word_t w;
      logic [4:0]         i0;
      logic [4:0]         i1;
      assign samp = {src[c*14 +: 14], 2'b00};
      // samples arrive twos complement; patterns with a format setting are held offset binary, the rest pass unchanged
      always_comb
      begin
        if (test_on)
          w = (pat_fmt && !offbin) ? pat ^ `ASO_MSB_FLIP : pat;
        else
          w = offbin ? samp ^ `ASO_MSB_FLIP : samp;
      end
      assign fmt_word[c] = w;
      // msb sits at bit 15; lsb of a short word sits at bit 16-len
      assign i0 = lsb_first ? 5'd16 - word_len + pos0 : 5'd15 - pos0;
      assign i1 = lsb_first ? 5'd16 - word_len + pos1 : 5'd15 - pos1;
      assign lane_bits[2*c]   = q.words[c][i0[3:0]];
      assign lane_bits[2*c+1] = one_lane ? 1'b0 : q.words[c][i1[3:0]];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic push;
  logic pop;

  assign push = i_sample_valid && (q.cnt != 2'd2);
  // test mode still drains the buffer so the source never stalls on it
  assign pop  = word_end && (q.cnt != 2'd0);

  always_comb
  begin
    d = q;
    // register writes from the configuration port
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        `ASO_REG_TEST:    d.test    = i_reg_wdata;
        `ASO_REG_FMT:     d.fmt     = i_reg_wdata;
        `ASO_REG_DRIVE:   d.drive   = i_reg_wdata;
        `ASO_REG_PHASE:   d.phase   = i_reg_wdata;
        `ASO_REG_U1_LOW:  d.u1_low  = i_reg_wdata;
        `ASO_REG_U1_HIGH: d.u1_high = i_reg_wdata;
        `ASO_REG_U2_LOW:  d.u2_low  = i_reg_wdata;
        `ASO_REG_U2_HIGH: d.u2_high = i_reg_wdata;
        `ASO_REG_PLL:     d.pll     = i_reg_wdata;
        default:          d.test    = q.test;
      endcase
    end
    // register reads, one cycle late; unmapped reads give zero
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `ASO_REG_TEST:    d.rdata = q.test;
        `ASO_REG_FMT:     d.rdata = q.fmt;
        `ASO_REG_DRIVE:   d.rdata = q.drive;
        `ASO_REG_PHASE:   d.rdata = q.phase;
        `ASO_REG_U1_LOW:  d.rdata = q.u1_low;
        `ASO_REG_U1_HIGH: d.rdata = q.u1_high;
        `ASO_REG_U2_LOW:  d.rdata = q.u2_low;
        `ASO_REG_U2_HIGH: d.rdata = q.u2_high;
        `ASO_REG_PLL:     d.rdata = q.pll;
        `ASO_REG_STATUS:  d.rdata = {5'h00, test_on, q.cnt};
        default:          d.rdata = 8'h00;
      endcase
    end
    // two-entry buffer
    if (push)
    begin
      d.mem[q.wp] = i_sample_data;
      d.wp        = ~q.wp;
    end
    if (pop)
    begin
      d.held = q.mem[q.rp];
      d.rp   = ~q.rp;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    // bit step and lane bit counters
    if (q.step == `ASO_STEPS_PER_BIT - 3'd1)
    begin
      d.step = 3'd0;
      d.idx  = word_end ? 4'd0 : q.idx + 4'd1;
    end
    else
    begin
      d.step = q.step + 3'd1;
    end
    // new words load one cycle before the registered marker rises
    if (word_end)
    begin
      d.words = fmt_word;
      d.lfmt  = q.fmt;
      d.alt   = ~q.alt;
      if (mode == `ASO_TM_PN9)
        d.pn9 = pn9_adv(q.pn9);
      if (mode == `ASO_TM_PN23)
        d.pn23 = pn23_adv(q.pn23);
    end
    // reseed while the reset bit is set
    if (q.test[`ASO_TEST_PN9_RST])
      d.pn9 = `ASO_PN9_SEED;
    if (q.test[`ASO_TEST_PN23_RST])
      d.pn23 = `ASO_PN23_SEED;
    // output stage: everything delayed by the same single cycle
    d.lanes = lane_bits;
    d.bclk  = (rel < 5'd6);
    d.frame = (q.idx < half_word);
    // synchronous reset
    if (!i_rst_b)
    begin
      d       = '0;
      d.test  = `ASO_RST_REG;
      d.fmt   = `ASO_RST_REG;
      d.lfmt  = `ASO_RST_REG;
      d.phase = `ASO_RST_PHASE;
      d.pn9   = `ASO_PN9_SEED;
      d.pn23  = `ASO_PN23_SEED;
    end
  end

  // single register stage for all state
  always_ff @(posedge i_clk_sys)
  begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: each bank carries its own clock pair, same timing

  assign o_reg_rdata          = q.rdata;
  assign o_sample_ready       = (q.cnt != 2'd2);
  assign o_bank1_serial_lanes = q.lanes[NUM_CH-1:0];
  assign o_bank2_serial_lanes = q.lanes[2*NUM_CH-1:NUM_CH];
  assign o_bank1_bit_clock    = q.bclk;
  assign o_bank2_bit_clock    = q.bclk;
  assign o_bank1_word_marker  = q.frame;
  assign o_bank2_word_marker  = q.frame;

endmodule : aso_formatter

// ---- logic/aso_map.svh ----
`ifndef ASO_MAP_SVH
`define ASO_MAP_SVH
// register offsets
`define ASO_REG_TEST      8'h0d
`define ASO_REG_FMT       8'h14
`define ASO_REG_DRIVE     8'h15
`define ASO_REG_PHASE     8'h16
`define ASO_REG_U1_LOW    8'h19
`define ASO_REG_U1_HIGH   8'h1a
`define ASO_REG_U2_LOW    8'h1b
`define ASO_REG_U2_HIGH   8'h1c
`define ASO_REG_PLL       8'h21
`define ASO_REG_STATUS    8'h22
// field positions
`define ASO_FMT_OFFBIN    0
`define ASO_FMT_ONE_LANE  1
`define ASO_FMT_LSB_FIRST 2
`define ASO_FMT_RES12     3
`define ASO_TEST_PN23_RST 4
`define ASO_TEST_PN9_RST  5
// reset values
`define ASO_RST_REG       8'h00
`define ASO_RST_PHASE     8'h03
`define ASO_PN9_SEED      9'h1ff
`define ASO_PN23_SEED     23'h7fffff
// test mode codes
`define ASO_TM_OFF        4'h0
`define ASO_TM_MID        4'h1
`define ASO_TM_POS_FS     4'h2
`define ASO_TM_NEG_FS     4'h3
`define ASO_TM_CHECKER    4'h4
`define ASO_TM_PN23       4'h5
`define ASO_TM_PN9        4'h6
`define ASO_TM_WORD_TOG   4'h7
`define ASO_TM_USER       4'h8
`define ASO_TM_BIT_TOG    4'h9
`define ASO_TM_SYNC       4'ha
`define ASO_TM_ONE_BIT    4'hb
`define ASO_TM_MIXED      4'hc
// pattern words, left aligned in 16 bits, offset binary form where format applies
`define ASO_PAT_MID       16'h8000
`define ASO_PAT_POS_FS    16'hfffc
`define ASO_PAT_ZERO      16'h0000
`define ASO_PAT_CHK_A     16'haaa8
`define ASO_PAT_CHK_B     16'h5554
`define ASO_PAT_SYNC16    16'h01fc
`define ASO_PAT_SYNC12    16'h03f0
`define ASO_PAT_MIXED16   16'ha19c
`define ASO_PAT_MIXED12   16'ha330
`define ASO_MSB_FLIP      16'h8000
// timing: fast clock steps per data bit (one step is 60 deg of a bit)
`define ASO_STEPS_PER_BIT 3'd6
`define ASO_STEPS_PER_BCK 5'd12
`define ASO_PHASE_MAX     5'd11
`define ASO_BITS_TWO16    4'd8
`define ASO_BITS_TWO12    4'd6
`define ASO_BITS_ONE16    4'd15
`define ASO_BITS_ONE12    4'd11
`endif

// ---- logic/aso_pkg.sv ----
package aso_pkg;
  typedef logic [13:0] aso_sample_t;
  typedef logic [15:0] aso_word_t;
  typedef enum logic {ASO_TWO_LANE, ASO_ONE_LANE} aso_lane_mode_t;
endpackage : aso_pkg

// ---- sim/aso_formatter_properties.sv ----
`timescale 1ns/100ps
module aso_formatter_properties #(
  parameter int NUM_CH = 8
) (
  input wire logic                 i_clk_sys,
  input wire logic                 i_rst_b,
  input wire logic [7:0]           i_reg_addr,
  input wire logic [7:0]           i_reg_wdata,
  input wire logic                 i_reg_wr,
  input wire logic                 i_reg_rd,
  input wire logic [7:0]           o_reg_rdata,
  input wire logic                 i_sample_valid,
  input wire logic [NUM_CH*14-1:0] i_sample_data,
  input wire logic                 o_sample_ready,
  input wire logic [NUM_CH-1:0]    o_bank1_serial_lanes,
  input wire logic [NUM_CH-1:0]    o_bank2_serial_lanes,
  input wire logic                 o_bank1_bit_clock,
  input wire logic                 o_bank2_bit_clock,
  input wire logic                 o_bank1_word_marker,
  input wire logic                 o_bank2_word_marker
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  // link timing: phase register stays at reset, so every half clock is six cycles
  sequence s_bck_half;
    $stable(o_bank1_bit_clock)[*5] ##1 $changed(o_bank1_bit_clock);
  endsequence
  sequence s_centred;
    ##3 $changed(o_bank1_bit_clock) ##6 $changed(o_bank1_bit_clock);
  endsequence
  property p_bck_period;
    $changed(o_bank1_bit_clock) |=> s_bck_half;
  endproperty
  property p_lane_hold;
    $changed(o_bank1_serial_lanes) |=> $stable(o_bank1_serial_lanes)[*5];
  endproperty
  property p_mark_hold;
    $rose(o_bank1_word_marker) |=> o_bank1_word_marker[*8];
  endproperty
  property p_mark_centre;
    $rose(o_bank1_word_marker) |-> s_centred;
  endproperty
  property p_mark_frame;
    $rose(o_bank1_word_marker) |=> $stable(o_bank1_serial_lanes)[*5];
  endproperty
  property p_banks_match;
    o_bank1_bit_clock == o_bank2_bit_clock && o_bank1_word_marker == o_bank2_word_marker;
  endproperty
  a_bck_period: assert property (p_bck_period) else $error("bit clock half period wrong");
  a_lane_hold: assert property (p_lane_hold) else $error("lane bit shorter than six cycles");
  a_mark_hold: assert property (p_mark_hold) else $error("word marker high too briefly");
  a_mark_centre: assert property (p_mark_centre) else $error("bit clock not centred on bits");
  a_mark_frame: assert property (p_mark_frame) else $error("first bit not aligned to marker");
  a_banks_match: assert property (p_banks_match) else $error("bank clock pairs differ");

  ////////////////////////////////////////////////////////////////////////////////
  // register port and buffer
  property p_unmapped_rd;
    i_reg_rd && i_reg_addr == 8'h40 |=> o_reg_rdata == 8'h00;
  endproperty
  property p_wr_rd;
    i_reg_wr && i_reg_addr == 8'h19 ##2 i_reg_rd && i_reg_addr == 8'h19 |=> o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  property p_rdata_hold;
    !i_reg_rd |=> $stable(o_reg_rdata);
  endproperty
  property p_ready_rel;
    $rose(i_rst_b) |=> o_sample_ready;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  a_wr_rd: assert property (p_wr_rd) else $error("user word readback wrong");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  a_ready_rel: assert property (p_ready_rel) else $error("ready low after reset");
endmodule : aso_formatter_properties

bind aso_formatter aso_formatter_properties #(.NUM_CH(NUM_CH)) u_props (.*);

// ---- sim/aso_lvds_receiver.sv ----
`timescale 1ns/100ps
module aso_lvds_receiver (
  input  wire logic        i_bit_clock,
  input  wire logic        i_word_marker,
  input  wire logic        i_one_lane,
  input  wire logic [1:0]  i_lanes,
  output logic      [15:0] o_word,
  output logic             o_word_tgl
);
  logic [31:0] acc;
  logic        prev_mark;

  // pll register left at reset: the bit clock here comes from the bench clock
  initial
  begin
    acc = 32'h0000_0000;
    prev_mark = 1'b0;
    o_word = 16'h0000;
    o_word_tgl = 1'b0;
  end

  // both edges carry data; a marker rise closes the word, so any length frames itself
  always @(i_bit_clock)
  begin
    if (i_word_marker && !prev_mark)
    begin
      o_word = acc[15:0];
      o_word_tgl = ~o_word_tgl;
      acc = 32'h0000_0000;
    end
    if (i_one_lane)
      acc = {acc[30:0], i_lanes[0]};
    else
      acc = {acc[29:0], i_lanes[1], i_lanes[0]};
    prev_mark = i_word_marker;
  end
endmodule : aso_lvds_receiver

// ---- sim/aso_formatter_tb.sv ----
`timescale 1ns/100ps
module aso_formatter_tb;
  logic         i_clk_sys;
  logic         i_rst_b;
  logic [7:0]   i_reg_addr;
  logic [7:0]   i_reg_wdata;
  logic         i_reg_wr;
  logic         i_reg_rd;
  logic [7:0]   o_reg_rdata;
  logic         i_sample_valid;
  logic [111:0] i_sample_data;
  logic         o_sample_ready;
  logic [7:0]   o_bank1_serial_lanes;
  logic [7:0]   o_bank2_serial_lanes;
  logic         o_bank1_bit_clock;
  logic         o_bank2_bit_clock;
  logic         o_bank1_word_marker;
  logic         o_bank2_word_marker;
  logic         one_lane;
  logic [15:0]  rx_word;
  logic         rx_tgl;
  logic [15:0]  exp_q[$];
  logic [15:0]  seed;
  int           failures;
  int           check_count;

  aso_formatter uut (.*);
  aso_lvds_receiver u_rx (.i_bit_clock(o_bank1_bit_clock), .i_word_marker(o_bank1_word_marker),
    .i_one_lane(one_lane), .i_lanes(o_bank1_serial_lanes[1:0]), .o_word(rx_word), .o_word_tgl(rx_tgl));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic check(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(posedge i_clk_sys);
    check({8'h00, e}, {8'h00, o_reg_rdata});
  endtask : reg_rd

  // skip words still in flight, then note the next four in the pattern's phase
  task automatic expect_words(input logic [15:0] a, input logic [15:0] b);
    repeat (4) @(rx_tgl);
    #1;
    if (rx_word === a && a !== b)
      exp_q = {b, a, b, a};
    else
      exp_q = {a, b, a, b};
    repeat (5) @(rx_tgl);
  endtask : expect_words

  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // clock, watchdog and word monitor
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  initial
  begin
    repeat (40000) @(posedge i_clk_sys);
    failures++;
    complete_run();
  end

  always @(rx_tgl)
    if (exp_q.size() > 0)
      check(exp_q.pop_front(), rx_word);

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: registers, converter data, then every pattern in format 0 and a subset of patterns in the other formats
  initial
  begin
    logic [47:0] plan [21];
    logic [7:0] fmt;
    logic [7:0] mode;
    logic [15:0] a;
    logic [15:0] b;
    plan = '{48'h00_01_0000_0000, 48'h00_02_7ffc_7ffc, 48'h00_03_8000_8000, 48'h00_04_aaa8_5554,
      48'h00_07_fffc_0000, 48'h00_08_a55a_3cc3, 48'h00_09_aaa8_aaa8, 48'h00_0a_01fc_01fc,
      48'h00_0b_8000_8000, 48'h00_0c_a19c_a19c, 48'h00_26_7f80_7f80, 48'h00_15_7ffc_7ffc,
      48'h01_01_8000_8000, 48'h01_02_fffc_fffc, 48'h01_03_0000_0000, 48'h01_04_aaa8_5554,
      48'h01_0c_a19c_a19c, 48'h01_26_ff80_ff80, 48'h04_0c_3985_3985, 48'h08_0c_0a33_0a33,
      48'h02_0c_a19c_a19c};
    i_rst_b = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_sample_valid = 1'b0;
    i_sample_data = '0;
    one_lane = 1'b0;
    seed = 16'h0046;
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    reg_rd(8'h0d, 8'h00);
    reg_rd(8'h16, 8'h03);
    reg_rd(8'h40, 8'h00);
    reg_wr(8'h19, 8'h5a);
    reg_rd(8'h19, 8'h5a);
    reg_wr(8'h1a, 8'ha5);
    reg_wr(8'h1b, 8'hc3);
    reg_wr(8'h1c, 8'h3c);
    i_sample_valid <= 1'b1;
    for (int f = 0; f < 2; f++)
    begin
      seed = lfsr_next(seed);
      i_sample_data <= {8{seed[13:0]}};
      reg_wr(8'h14, 8'(f));
      a = {seed[13] ^ f[0], seed[12:0], 2'b00};
      expect_words(a, a);
      check(16'h0000, {15'h0000, o_sample_ready});
      $display("data test %0d done", f);
    end
    for (int i = 0; i < 21; i++)
    begin
      {fmt, mode, a, b} = plan[i];
      one_lane = fmt[1];
      reg_wr(8'h14, fmt);
      reg_wr(8'h0d, mode);
      expect_words(a, b);
      $display("pattern test %0d done", i);
    end
    @(posedge i_clk_sys);
    i_sample_valid <= 1'b0;
    repeat (300) @(posedge i_clk_sys);
    check(16'h0001, {15'h0000, o_sample_ready});
    $display("drain test done");
    complete_run();
  end
endmodule : aso_formatter_tb
